// ### hw/dma_wrap_defines.svh
// register offsets, field positions and codes of the repeat-area address update block
`ifndef DMA_WRAP_DEFINES_SVH
`define DMA_WRAP_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DW_OFS_CTRL      8'h00
`define DW_OFS_MODE      8'h04
`define DW_OFS_SRC       8'h08
`define DW_OFS_DST       8'h0c
`define DW_OFS_OFFS      8'h10
`define DW_OFS_BLK       8'h14
`define DW_OFS_STAT      8'h18
`define DW_OFS_CLR       8'h1c
`define DW_OFS_IEN       8'h20

// ----------------------------------------------------------------------
// address update control register fields
// ----------------------------------------------------------------------
`define DW_SRC_MODE_HI   21
`define DW_SRC_MODE_LO   20
`define DW_DST_MODE_HI   17
`define DW_DST_MODE_LO   16
`define DW_SRC_IE_BIT    15
`define DW_SRC_AREA_HI   12
`define DW_SRC_AREA_LO   8
`define DW_DST_IE_BIT    7
`define DW_DST_AREA_HI   4
`define DW_DST_AREA_LO   0

// ----------------------------------------------------------------------
// channel mode control register fields
// ----------------------------------------------------------------------
`define DW_TE_BIT        0
`define DW_BLK_BIT       1
`define DW_FLAG_BIT      2

// ----------------------------------------------------------------------
// interrupt status / clear / enable layout
// ----------------------------------------------------------------------
`define DW_ST_WRAP       0
`define DW_ST_SRC        1
`define DW_ST_DST        2
`define DW_ST_BLK        3
`define DW_ST_W          4

// ----------------------------------------------------------------------
// update modes, area codes, reset values
// ----------------------------------------------------------------------
`define DW_UPD_FIXED     2'h0
`define DW_UPD_OFFSET    2'h1
`define DW_UPD_INC       2'h2
`define DW_UPD_DEC       2'h3
`define DW_AREA_NONE     5'h00
`define DW_AREA_MAX      5'h1b
`define DW_SIZE_LONG     2'h2
`define DW_RST_WORD      32'h0000_0000

`endif

// ### hw/dma_wrap_pkg.sv
// types and shared decode for the repeat-area address update block
`include "dma_wrap_defines.svh"

package dma_wrap_pkg;

   // ----------------------------------------------------------------------
   // address update control fields
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] src_update_mode;    // source update method
      logic       src_wrap_irq_en;    // stop + flag on source overflow
      logic [4:0] src_wrap_area_size; // source area code
      logic       dst_wrap_irq_en;    // stop + flag on destination overflow
      logic [4:0] dst_wrap_area_size; // destination area code
      logic [1:0] dst_update_mode;    // destination update method
   } ctrl_type;

   // one access from the transfer engine
   typedef struct packed {
      logic       valid;              // one-cycle access pulse
      logic [1:0] size;               // 0 byte, 1 word, 2 long
   } acc_req_type;

   // area code selects a repeat area (111xx and 00000 do not)
   function automatic logic area_active(input logic [4:0] code);
      area_active = (code != `DW_AREA_NONE) && (code <= `DW_AREA_MAX);
   endfunction

endpackage

// ### hw/wrap_addr_calc.sv
// next-address computation for one pointer, with repeat-area wrap
`timescale 1ns/1ps
`include "dma_wrap_defines.svh"

module wrap_addr_calc
   import dma_wrap_pkg::*;
#(
   parameter int AW = 32
) (
   // current pointer and settings
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [1:0]    i_mode,
   input  wire logic [1:0]    i_size,
   input  wire logic [4:0]    i_area,
   input  wire logic [AW-1:0] i_offset,
   // result
   output logic      [AW-1:0] o_next,
   output logic               o_overflow
);

   // ----------------------------------------------------------------------
   // combinational update
   // ----------------------------------------------------------------------
   logic          on;    // repeat area in use
   logic [AW-1:0] step;  // 1, 2 or 4
   logic [AW-1:0] mask;  // bits that may change
   logic [AW-1:0] low;   // area-relative part
   logic [AW-1:0] upper; // frozen part
   logic [AW:0]   sum;   // add with carry

   always_comb begin
      on    = area_active(i_area);
      // oversize codes clamp to long
      step  = AW'(1) << ((i_size > `DW_SIZE_LONG) ? `DW_SIZE_LONG : i_size);
      mask  = on ? ((AW'(1) << i_area) - AW'(1)) : '1;
      low   = i_addr & mask;
      upper = i_addr & ~mask;
      sum   = {1'b0, low} + {1'b0, (i_mode == `DW_UPD_OFFSET) ? i_offset : step};
      o_next     = i_addr;
      o_overflow = 1'b0;
      unique case (i_mode)
         `DW_UPD_FIXED: begin
            o_next = i_addr;
         end
         `DW_UPD_OFFSET, `DW_UPD_INC: begin
            // carry past the area: back to its first address
            o_overflow = on && ((|(sum[AW-1:0] & ~mask)) || sum[AW]);
            o_next     = o_overflow ? upper : (upper | (sum[AW-1:0] & mask));
         end
         `DW_UPD_DEC: begin
            // borrow below the area: to its last address
            o_overflow = on && (low < step);
            o_next     = o_overflow ? (upper | mask)
                                    : (upper | ((low - step) & mask));
         end
      endcase
   end

endmodule // wrap_addr_calc

// ### hw/dma_repeat_area_address_update.sv
// one dma channel's source/destination address update with repeat areas
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "dma_wrap_defines.svh"

module dma_repeat_area_address_update
   import dma_wrap_pkg::*;
#(
   parameter int AW = 32, // pointer width
   parameter int BW = 16  // block size counter width
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // transfer engine
   input  wire acc_req_type i_acc,
   output logic [AW-1:0]    o_src_addr,
   output logic [AW-1:0]    o_dst_addr,
   output logic             o_transfer_enable,
   // interrupt
   output logic             o_irq
);

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   ctrl_type             ctrl_q;      // address update control
   logic                 te_q;        // channel_transfer_enable
   logic                 blk_mode_q;  // block transfer mode
   logic [AW-1:0]        src_q;       // source_pointer_reg
   logic [AW-1:0]        dst_q;       // destination_pointer_reg
   logic [AW-1:0]        offs_q;      // offset for update mode 01
   logic [BW-1:0]        blk_size_q;  // accesses per block
   logic [BW-1:0]        blk_cnt_q;   // accesses done in block
   logic                 pend_q;      // deferred stop waiting
   logic [`DW_ST_W-1:0]  stat_q;      // sticky events
   logic [`DW_ST_W-1:0]  ien_q;       // event enables
   logic                 irq_q;       // interrupt output flop
   logic [31:0]          rdata_q;     // read data flop

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   logic                 wr_ctrl;     // write to control
   logic                 wr_mode;     // write to mode
   logic                 wr_src;      // write to source pointer
   logic                 wr_dst;      // write to destination pointer
   logic                 wr_clr;      // write to clear register

   assign wr_ctrl = i_wr && (i_addr == `DW_OFS_CTRL);
   assign wr_mode = i_wr && (i_addr == `DW_OFS_MODE);
   assign wr_src  = i_wr && (i_addr == `DW_OFS_SRC);
   assign wr_dst  = i_wr && (i_addr == `DW_OFS_DST);
   assign wr_clr  = i_wr && (i_addr == `DW_OFS_CLR);

   // ----------------------------------------------------------------------
   // next-address units
   // ----------------------------------------------------------------------
   logic [AW-1:0]        src_next;    // source after this access
   logic [AW-1:0]        dst_next;    // destination after this access
   logic                 src_ovf;     // source left its area
   logic                 dst_ovf;     // destination left its area

   // source pointer
   wrap_addr_calc #(.AW(AW)) u_src_calc (
      .i_addr     (src_q),
      .i_mode     (ctrl_q.src_update_mode),
      .i_size     (i_acc.size),
      .i_area     (ctrl_q.src_wrap_area_size),
      .i_offset   (offs_q),
      .o_next     (src_next),
      .o_overflow (src_ovf)
   );

   // destination pointer, same encoding as source
   wrap_addr_calc #(.AW(AW)) u_dst_calc (
      .i_addr     (dst_q),
      .i_mode     (ctrl_q.dst_update_mode),
      .i_size     (i_acc.size),
      .i_area     (ctrl_q.dst_wrap_area_size),
      .i_offset   (offs_q),
      .o_next     (dst_next),
      .o_overflow (dst_ovf)
   );

   // ----------------------------------------------------------------------
   // overflow and stop decision
   // ----------------------------------------------------------------------
   logic                 go;          // access taken this cycle
   logic                 src_evt;     // source overflow inside an area
   logic                 dst_evt;     // destination overflow inside an area
   logic                 src_hit;     // source overflow that stops
   logic                 dst_hit;     // destination overflow that stops
   logic                 hit;         // either stopping overflow
   logic                 blk_last;    // access closes a block
   logic                 stop_now;    // clear enable this cycle

   // accesses only count while the channel is enabled
   assign go       = i_acc.valid && te_q;
   // an enable bit alone does nothing without an area
   assign src_evt  = go && src_ovf && area_active(ctrl_q.src_wrap_area_size);
   assign dst_evt  = go && dst_ovf && area_active(ctrl_q.dst_wrap_area_size);
   assign src_hit  = src_evt && ctrl_q.src_wrap_irq_en;
   assign dst_hit  = dst_evt && ctrl_q.dst_wrap_irq_en;
   // each side judged on its own
   assign hit      = src_hit || dst_hit;
   // a zero block size behaves as one access per block
   assign blk_last = blk_mode_q &&
                     (({1'b0, blk_cnt_q} + (BW+1)'(1)) >= {1'b0, blk_size_q});
   // in block mode the stop waits for the block to finish
   assign stop_now = go && (blk_mode_q ? (blk_last && (hit || pend_q)) : hit);

   // ----------------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------------
   // reserved positions are simply not stored
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_q <= '0;
      end else if (wr_ctrl) begin
         ctrl_q.src_update_mode    <= i_wdata[`DW_SRC_MODE_HI:`DW_SRC_MODE_LO];
         ctrl_q.dst_update_mode    <= i_wdata[`DW_DST_MODE_HI:`DW_DST_MODE_LO];
         ctrl_q.src_wrap_irq_en    <= i_wdata[`DW_SRC_IE_BIT];
         ctrl_q.src_wrap_area_size <= i_wdata[`DW_SRC_AREA_HI:`DW_SRC_AREA_LO];
         ctrl_q.dst_wrap_irq_en    <= i_wdata[`DW_DST_IE_BIT];
         ctrl_q.dst_wrap_area_size <= i_wdata[`DW_DST_AREA_HI:`DW_DST_AREA_LO];
      end
   end

   // ----------------------------------------------------------------------
   // transfer enable and block mode
   // ----------------------------------------------------------------------
   // a software write beats a hardware stop in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         te_q       <= 1'b0;
         blk_mode_q <= 1'b0;
      end else if (wr_mode) begin
         te_q       <= i_wdata[`DW_TE_BIT];
         blk_mode_q <= i_wdata[`DW_BLK_BIT];
      end else if (stop_now) begin
         te_q       <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // pointers
   // ----------------------------------------------------------------------
   // pointers keep their value across a stop, so a restart continues
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         src_q <= '0;
      end else if (wr_src) begin
         src_q <= i_wdata[AW-1:0];
      end else if (go) begin
         src_q <= src_next;
      end
   end

   // destination pointer
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         dst_q <= '0;
      end else if (wr_dst) begin
         dst_q <= i_wdata[AW-1:0];
      end else if (go) begin
         dst_q <= dst_next;
      end
   end

   // ----------------------------------------------------------------------
   // offset and block size
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         offs_q     <= '0;
         blk_size_q <= '0;
      end else begin
         if (i_wr && (i_addr == `DW_OFS_OFFS)) begin
            offs_q <= i_wdata[AW-1:0];
         end
         if (i_wr && (i_addr == `DW_OFS_BLK)) begin
            blk_size_q <= i_wdata[BW-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // block progress and deferred stop
   // ----------------------------------------------------------------------
   // the count survives a stop so a resumed block ends where it should
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         blk_cnt_q <= '0;
      end else if (wr_mode && !i_wdata[`DW_BLK_BIT]) begin
         blk_cnt_q <= '0; // leaving block mode
      end else if (go && blk_mode_q) begin
         blk_cnt_q <= blk_last ? '0 : (blk_cnt_q + BW'(1));
      end
   end

   // overflow seen mid-block waits here for the block end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pend_q <= 1'b0;
      end else if (stop_now) begin
         pend_q <= 1'b0;
      end else if (go && blk_mode_q && hit) begin
         pend_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // interrupt status, enable and output
   // ----------------------------------------------------------------------
   logic [`DW_ST_W-1:0]  stat_set;    // events this cycle

   always_comb begin
      stat_set               = '0;
      stat_set[`DW_ST_WRAP]  = stop_now; // wrap_overflow_irq_flag
      stat_set[`DW_ST_SRC]   = src_evt;
      stat_set[`DW_ST_DST]   = dst_evt;
      stat_set[`DW_ST_BLK]   = go && blk_last;
   end

   // a new event outranks a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~(wr_clr ? i_wdata[`DW_ST_W-1:0] : '0)) | stat_set;
      end
   end

   // enable register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ien_q <= '0;
      end else if (i_wr && (i_addr == `DW_OFS_IEN)) begin
         ien_q <= i_wdata[`DW_ST_W-1:0];
      end
   end

   // level output, one flop behind the status
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & ien_q);
      end
   end

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   logic [31:0]          rd_mux;      // selected read word

   always_comb begin
      rd_mux = `DW_RST_WORD;
      unique case (i_addr)
         `DW_OFS_CTRL: begin
            // reserved positions stay zero
            rd_mux[`DW_SRC_MODE_HI:`DW_SRC_MODE_LO] = ctrl_q.src_update_mode;
            rd_mux[`DW_DST_MODE_HI:`DW_DST_MODE_LO] = ctrl_q.dst_update_mode;
            rd_mux[`DW_SRC_IE_BIT]                  = ctrl_q.src_wrap_irq_en;
            rd_mux[`DW_SRC_AREA_HI:`DW_SRC_AREA_LO] = ctrl_q.src_wrap_area_size;
            rd_mux[`DW_DST_IE_BIT]                  = ctrl_q.dst_wrap_irq_en;
            rd_mux[`DW_DST_AREA_HI:`DW_DST_AREA_LO] = ctrl_q.dst_wrap_area_size;
         end
         `DW_OFS_MODE: begin
            rd_mux[`DW_TE_BIT]   = te_q;
            rd_mux[`DW_BLK_BIT]  = blk_mode_q;
            rd_mux[`DW_FLAG_BIT] = stat_q[`DW_ST_WRAP];
         end
         `DW_OFS_SRC:  rd_mux[AW-1:0] = src_q;
         `DW_OFS_DST:  rd_mux[AW-1:0] = dst_q;
         `DW_OFS_OFFS: rd_mux[AW-1:0] = offs_q;
         `DW_OFS_BLK:  rd_mux[BW-1:0] = blk_size_q;
         `DW_OFS_STAT: rd_mux[`DW_ST_W-1:0] = stat_q;
         `DW_OFS_IEN:  rd_mux[`DW_ST_W-1:0] = ien_q;
         // clear register and unmapped addresses read zero
         default:      rd_mux = `DW_RST_WORD;
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rdata_q <= `DW_RST_WORD;
      end else if (i_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= `DW_RST_WORD;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign o_rdata           = rdata_q;
   assign o_src_addr        = src_q;
   assign o_dst_addr        = dst_q;
   assign o_transfer_enable = te_q;
   assign o_irq             = irq_q;

endmodule // dma_repeat_area_address_update

// ### tb/dma_wrap_assertions.sv
// concurrent checks on the repeat-area address update block ports
`timescale 1ns/1ps

module dma_wrap_checker
   import dma_wrap_pkg::*;
#(
   parameter int AW = 32
) (
   // clock, reset, register port
   input wire logic          i_clk,
   input wire logic          i_nrst,
   input wire logic [7:0]    i_addr,
   input wire logic [31:0]   i_wdata,
   input wire logic          i_wr,
   input wire logic          i_rd,
   input wire logic [31:0]   o_rdata,
   // engine side
   input wire acc_req_type   i_acc,
   input wire logic [AW-1:0] o_src_addr,
   input wire logic [AW-1:0] o_dst_addr,
   input wire logic          o_transfer_enable,
   input wire logic          o_irq
);
   logic [31:0]   ctrl_q;       // shadow of control word
   logic          blk_q;        // shadow of block mode bit
   logic [AW-1:0] smask, dmask; // low-bit masks of the areas
   logic [2:0]    step;         // bytes per access
   logic          go, s_on, d_on, s_ovf, d_unf;

   // shadow registers follow software writes
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_q <= '0;
         blk_q  <= 1'b0;
      end else if (i_wr && i_addr == 8'h00) begin
         ctrl_q <= i_wdata;
      end else if (i_wr && i_addr == 8'h04) begin
         blk_q <= i_wdata[1];
      end
   end

   // accepted access and predicted area overflow
   always_comb begin
      smask = (AW'(1) << ctrl_q[12:8]) - AW'(1);
      dmask = (AW'(1) << ctrl_q[4:0]) - AW'(1);
      step  = (i_acc.size == 2'h0) ? 3'h1 : (i_acc.size == 2'h1) ? 3'h2 : 3'h4;
      go    = i_acc.valid && o_transfer_enable && !i_wr;
      s_on  = ctrl_q[12:8] != 5'h00 && ctrl_q[12:8] <= 5'h1b;
      d_on  = ctrl_q[4:0] != 5'h00 && ctrl_q[4:0] <= 5'h1b;
      s_ovf = s_on && ctrl_q[21:20] == 2'h2 && ((o_src_addr & smask) + AW'(step)) > smask;
      d_unf = d_on && ctrl_q[17:16] == 2'h3 && (o_dst_addr & dmask) < AW'(step);
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_rsvd;
      i_rd && i_addr == 8'h00 |=> o_rdata[14:13] == 2'h0 && o_rdata[6:5] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
   property p_dec;
      go && ctrl_q[17:16] == 2'h3 && !d_on |=> o_dst_addr == $past(o_dst_addr) - AW'($past(step));
   endproperty
   a_dec: assert property (p_dec) else $error("destination decrement wrong");
   property p_hold;
      go && s_on |=> (o_src_addr >> $past(ctrl_q[12:8])) ==
                     ($past(o_src_addr) >> $past(ctrl_q[12:8]));
   endproperty
   a_hold: assert property (p_hold) else $error("source upper bits moved");
   property p_src_stop;
      go && s_ovf && ctrl_q[15] && !blk_q |=> !o_transfer_enable;
   endproperty
   a_src_stop: assert property (p_src_stop) else $error("src overflow did not stop");
   property p_dst_stop;
      go && d_unf && ctrl_q[7] && !blk_q |=> !o_transfer_enable;
   endproperty
   a_dst_stop: assert property (p_dst_stop) else $error("dest overflow did not stop");
   property p_src_wrap;
      go && s_ovf |=> o_src_addr == ($past(o_src_addr) & ~$past(smask));
   endproperty
   a_src_wrap: assert property (p_src_wrap) else $error("source did not wrap to start");
   property p_dst_wrap;
      go && d_unf |=> o_dst_addr == ($past(o_dst_addr) | $past(dmask));
   endproperty
   a_dst_wrap: assert property (p_dst_wrap) else $error("dest did not wrap to end");
   property p_no_ie;
      go && !ctrl_q[15] && !ctrl_q[7] |=> o_transfer_enable;
   endproperty
   a_no_ie: assert property (p_no_ie) else $error("stop with enables clear");
   property p_no_area;
      go && !s_on && !d_on |=> o_transfer_enable;
   endproperty
   a_no_area: assert property (p_no_area) else $error("stop without area");
endmodule // dma_wrap_checker

// ### tb/acc_engine_model.sv
// transfer engine stand-in issuing access pulses
`timescale 1ns/1ps

module acc_engine_model
   import dma_wrap_pkg::*;
(
   // clock
   input  wire logic  i_clk,
   // access pulses toward the block
   output acc_req_type o_acc
);
   initial o_acc = '0;

   // n accesses of one size, gap idle cycles after each
   task automatic issue(input int n, input logic [1:0] sz, input int gap);
      @(posedge i_clk);
      for (int i = 0; i < n; i++) begin
         o_acc <= '{valid: 1'b1, size: sz};
         @(posedge i_clk);
         if (gap > 0 || i == n - 1) begin
            // idle size wanders so a stale value is never trusted
            o_acc <= '{valid: 1'b0, size: 2'($urandom)};
            repeat (gap) @(posedge i_clk);
         end
      end
   endtask
endmodule // acc_engine_model

// ### tb/dma_repeat_area_address_update_tb_top.sv
// self-checking bench for the repeat-area address update block
`timescale 1ns/1ps
`include "dma_wrap_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module dma_repeat_area_address_update_tb_top
   import dma_wrap_pkg::*;
;
   logic        i_clk, i_nrst, i_wr, i_rd, o_transfer_enable, o_irq;
   logic        rd_seen = 1'b0;          // read answer due this cycle
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, o_src_addr, o_dst_addr, hi, exp_v;
   logic [31:0] exp_q[$];                // expected read data, oldest first
   acc_req_type i_acc;
   int          n_mismatch = 0;
   int          compares   = 0;
   int          cyc        = 0;

   dma_repeat_area_address_update dma_repeat_area_address_update_inst (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_acc(i_acc), .o_src_addr(o_src_addr),
      .o_dst_addr(o_dst_addr), .o_transfer_enable(o_transfer_enable), .o_irq(o_irq));
   acc_engine_model acc_engine_model_inst (.i_clk(i_clk), .o_acc(i_acc));

   // 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // ----------------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_addr <= a; i_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   task automatic acc(input int n, input logic [1:0] s, input int g);
      acc_engine_model_inst.issue(n, s, g);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // read answers compared with the oldest note
   always @(posedge i_clk) begin
      if (rd_seen) begin
         exp_v = exp_q.pop_front();
         `CHK(o_rdata, exp_v)
      end
      rd_seen <= i_rd && i_nrst;
   end

   // hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      {i_nrst, i_wr, i_rd, i_addr, i_wdata} = '0;
      hi = $urandom(30265);
      hi = $urandom & 32'hffff_fff0;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      // reset values and an unmapped place
      rd(`DW_OFS_CTRL, 32'h0);
      rd(`DW_OFS_MODE, 32'h0);
      rd(8'h30, 32'h0);
      wr(`DW_OFS_CTRL, 32'hffff_ffff);
      rd(`DW_OFS_CTRL, 32'h0033_9f9f);
      // source wrap with stop, interrupt raised then cleared
      wr(`DW_OFS_IEN, 32'h1);
      wr(`DW_OFS_CTRL, 32'h0020_8200);
      wr(`DW_OFS_SRC, hi | 32'h3);
      wr(`DW_OFS_MODE, 32'h1);
      acc(1, 2'h2, 0);
      rd(`DW_OFS_SRC, hi);
      rd(`DW_OFS_MODE, 32'h4);
      rd(`DW_OFS_STAT, 32'h3);
      `CHK(o_irq, 1'b1)
      `CHK(o_src_addr, hi)
      `CHK(o_transfer_enable, 1'b0)
      wr(`DW_OFS_CLR, 32'hf);
      repeat (2) @(negedge i_clk);
      `CHK(o_irq, 1'b0)
      // destination decrement, back to back, masked interrupt
      wr(`DW_OFS_IEN, 32'h0);
      wr(`DW_OFS_CTRL, 32'h0003_0083);
      wr(`DW_OFS_DST, hi | 32'h2);
      wr(`DW_OFS_MODE, 32'h1);
      acc(2, 2'h1, 0);
      rd(`DW_OFS_DST, hi | 32'h7);
      `CHK(o_dst_addr, hi | 32'h7)
      rd(`DW_OFS_STAT, 32'h5);
      rd(`DW_OFS_MODE, 32'h4);
      `CHK(o_irq, 1'b0)
      wr(`DW_OFS_CLR, 32'hf);
      // enables clear: wrap without stop
      wr(`DW_OFS_CTRL, 32'h0020_0200);
      wr(`DW_OFS_SRC, hi | 32'h3);
      wr(`DW_OFS_MODE, 32'h1);
      acc(1, 2'h2, 0);
      rd(`DW_OFS_SRC, hi);
      rd(`DW_OFS_MODE, 32'h1);
      rd(`DW_OFS_STAT, 32'h2);
      wr(`DW_OFS_CLR, 32'hf);
      // no area and a prohibited area code: enables ignored
      wr(`DW_OFS_CTRL, 32'h0023_9c80);
      wr(`DW_OFS_SRC, 32'h0000_0ffb);
      wr(`DW_OFS_DST, 32'h0000_1000);
      acc(1, 2'h0, 1);
      acc(1, 2'h2, 0);
      rd(`DW_OFS_SRC, 32'h0000_1000);
      rd(`DW_OFS_DST, 32'h0000_0ffb);
      rd(`DW_OFS_MODE, 32'h1);
      rd(`DW_OFS_STAT, 32'h0);
      // offset update mode wraps like an increment, back to the area start
      wr(`DW_OFS_OFFS, 32'h6);
      wr(`DW_OFS_CTRL, 32'h0010_0300);
      wr(`DW_OFS_SRC, hi | 32'h4);
      acc(1, 2'h0, 0);
      rd(`DW_OFS_SRC, hi);
      // block mode defers the stop, then resume
      wr(`DW_OFS_MODE, 32'h0);
      wr(`DW_OFS_BLK, 32'h4);
      wr(`DW_OFS_CTRL, 32'h0020_8100);
      wr(`DW_OFS_SRC, hi);
      wr(`DW_OFS_IEN, 32'h1);
      wr(`DW_OFS_MODE, 32'h3);
      acc(2, 2'h0, 1);
      rd(`DW_OFS_MODE, 32'h3);
      rd(`DW_OFS_SRC, hi);
      acc(2, 2'h0, 0);
      rd(`DW_OFS_MODE, 32'h6);
      `CHK(o_irq, 1'b1)
      acc(1, 2'h0, 0);
      rd(`DW_OFS_SRC, hi);
      wr(`DW_OFS_MODE, 32'h3);
      acc(1, 2'h0, 0);
      rd(`DW_OFS_SRC, hi | 32'h1);
      rd(`DW_OFS_MODE, 32'h7);
      rd(`DW_OFS_STAT, 32'hb);
      repeat (3) @(posedge i_clk);
      tally_and_finish();
   end
endmodule // dma_repeat_area_address_update_tb_top

bind dma_repeat_area_address_update dma_wrap_checker #(.AW(AW)) dma_wrap_checker_inst (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_acc(i_acc), .o_src_addr(o_src_addr),
   .o_dst_addr(o_dst_addr), .o_transfer_enable(o_transfer_enable), .o_irq(o_irq));
